// *** dmpd_divider.sv ***
// divide-by-N synthesizer counter with reference and output dividers
`timescale 1ns/1ps
`default_nettype none
module dmpd_divider
    import dmpd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        tuned_oscillator_clock,
    input  wire logic [3:0]  preset_units,
    input  wire logic [3:0]  preset_tens,
    input  wire logic        ref_clk,
    input  wire logic        ext_ref_detect,
    input  wire logic        int_ref,
    input  wire logic        ext_ref,
    input  wire logic        loop33_clk,
    input  wire logic        pfd_large_pulse,
    output logic             terminal_pulse,
    output logic             pd_terminal,
    output logic             modulus_select,
    output logic             div10_out,
    output logic             ref_sel,
    output logic             ref_div3,
    output logic             ref_1mhz,
    output logic             ref_100khz,
    output logic             loop33_div10,
    output logic             unlocked
);
    // all internal counting runs on clk; edge inputs are synchronised
    typedef struct packed {
        logic [1:0] osc_s;
        logic [1:0] int_s;
        logic [1:0] ext_s;
        logic [1:0] l33_s;
        logic [1:0] det_s;
        logic [1:0] pfd_s;
        logic       osc_d;
        logic       ref_d;
        logic       l33_d;
        logic [3:0] pre;
        logic [3:0] low;
        logic [3:0] high;
        logic       mod_ff;
        logic       tc;
        logic [3:0] out10;
        logic       out10_q;
        logic [1:0] r3;
        logic       r3_q;
        logic [3:0] r10;
        logic [3:0] r100;
        logic       r1m_q, r100k_q;
        logic [3:0] l10;
        logic       l10_q;
        logic [3:0] lock_cnt;
        logic       unl;
    } dmpd_state_s;

    dmpd_state_s st;
    dmpd_state_s next_st;
    logic osc_rise, ref_rise, l33_rise, pre_wrap, low_dis;
    logic ref_lvl;

    always_comb begin
        next_st = st;
        next_st.osc_s = {st.osc_s[0], tuned_oscillator_clock};
        // each source synchronised alone: a mux ahead of the flops
        // would let a detect change glitch the counted waveform
        next_st.int_s = {st.int_s[0], int_ref};
        next_st.ext_s = {st.ext_s[0], ext_ref};
        next_st.l33_s = {st.l33_s[0], loop33_clk};
        next_st.det_s = {st.det_s[0], ext_ref_detect};
        next_st.pfd_s = {st.pfd_s[0], pfd_large_pulse};
        next_st.osc_d = st.osc_s[1];
        ref_lvl = st.det_s[1] ? st.ext_s[1] : st.int_s[1];
        next_st.ref_d = ref_lvl;
        next_st.l33_d = st.l33_s[1];
        osc_rise = st.osc_s[1] & ~st.osc_d;
        ref_rise = ref_lvl & ~st.ref_d;
        l33_rise = st.l33_s[1] & ~st.l33_d;
        // low decade spent: stop it and select divide by 10
        low_dis  = (st.low == DMPD_ZERO);
        pre_wrap = (st.pre == (low_dis ? DMPD_PRE_LO : DMPD_PRE_HI));
        next_st.tc = 1'b0;
        if (osc_rise) begin
            next_st.pre = pre_wrap ? DMPD_ZERO : st.pre + 4'h1;
            if (pre_wrap) begin
                if (st.high == DMPD_ZERO && st.mod_ff == 1'b0) begin
                    next_st.tc     = 1'b1;
                    next_st.low    = preset_units;
                    next_st.high   = preset_tens;
                    next_st.mod_ff = 1'b1;
                end else if (st.high == DMPD_ZERO) begin
                    next_st.mod_ff = 1'b0;
                    if (!low_dis)
                        next_st.low = st.low - 4'h1;
                end else begin
                    next_st.high = st.high - 4'h1;
                    if (!low_dis)
                        next_st.low = st.low - 4'h1;
                end
            end
            // output stage divides oscillator by ten
            next_st.out10 = (st.out10 == DMPD_DIV10_MAX) ? DMPD_ZERO
                            : st.out10 + 4'h1;
            next_st.out10_q = (next_st.out10 < DMPD_HALF10);
        end
        // one clock wide, so the loop detector sees one clean edge
        next_st.r3_q = 1'b0;
        if (ref_rise) begin
            next_st.r3   = (st.r3 == DMPD_DIV3_MAX) ? 2'h0 : st.r3 + 2'h1;
            next_st.r3_q = (st.r3 == DMPD_DIV3_MAX);
            next_st.r10  = (st.r10 == DMPD_DIV10_MAX) ? DMPD_ZERO
                           : st.r10 + 4'h1;
            next_st.r1m_q = (next_st.r10 < DMPD_HALF10);
            if (st.r10 == DMPD_DIV10_MAX) begin
                next_st.r100 = (st.r100 == DMPD_DIV10_MAX) ? DMPD_ZERO
                               : st.r100 + 4'h1;
                next_st.r100k_q = (next_st.r100 < DMPD_HALF10);
            end
        end
        if (l33_rise) begin
            next_st.l10   = (st.l10 == DMPD_DIV10_MAX) ? DMPD_ZERO
                            : st.l10 + 4'h1;
            next_st.l10_q = (next_st.l10 < DMPD_HALF10);
        end
        // large pulse held several clocks means frequency error
        if (st.pfd_s[1]) begin
            if (st.lock_cnt != DMPD_LOCK_LIM)
                next_st.lock_cnt = st.lock_cnt + 4'h1;
        end else begin
            next_st.lock_cnt = DMPD_ZERO;
        end
        if (st.pfd_s[1] && st.lock_cnt == DMPD_LOCK_LIM)
            next_st.unl = 1'b1;
        else if (!st.pfd_s[1] && !st.osc_s[1] && st.tc)
            next_st.unl = 1'b0;
        else if (!st.pfd_s[1] && st.lock_cnt == DMPD_ZERO)
            next_st.unl = st.unl & st.pfd_s[0];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign terminal_pulse = st.tc;
    assign pd_terminal    = st.tc;
    assign modulus_select = (st.low != DMPD_ZERO);
    assign div10_out      = st.out10_q;
    assign ref_sel        = st.det_s[1];
    assign ref_div3       = st.r3_q;
    assign ref_1mhz       = st.r1m_q;
    assign ref_100khz     = st.r100k_q;
    assign loop33_div10   = st.l10_q;
    assign unlocked       = st.unl;
endmodule : dmpd_divider
`default_nettype wire

// *** dmpd_divider_properties.sv ***
// concurrent checks on the divider top ports
`timescale 1ns/1ps
`default_nettype none
module dmpd_divider_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ext_ref_detect,
    input wire logic pfd_large_pulse,
    input wire logic ref_sel,
    input wire logic terminal_pulse,
    input wire logic pd_terminal,
    input wire logic div10_out,
    input wire logic ref_div3,
    input wire logic unlocked
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_pd_copy: assert property (pd_terminal == terminal_pulse)
        else $error("detector copy differs");
    a_term_gap: assert property (terminal_pulse |=> !terminal_pulse[*8])
        else $error("terminal pulses too close");
    a_ref_ext: assert property (ext_ref_detect[*6] |-> ref_sel)
        else $error("external source not chosen");
    a_ref_int: assert property (!ext_ref_detect[*6] |-> !ref_sel)
        else $error("internal source not chosen");
    a_no_lock: assert property (pfd_large_pulse[*8] |-> ##[0:4] unlocked)
        else $error("unlock not flagged");
    a_relock: assert property (!pfd_large_pulse[*8] |-> !unlocked)
        else $error("unlock not cleared");
    a_div3_one: assert property (ref_div3 |=> !ref_div3)
        else $error("div3 pulse too wide");
    a_out_hold: assert property ($rose(div10_out) |=> div10_out[*8])
        else $error("div10 half period short");
endmodule : dmpd_divider_props
bind dmpd_divider dmpd_divider_props props_u (.*);
`default_nettype wire

// *** dmpd_divider_tb_top.sv ***
// self-checking bench for the dual modulus divider
`timescale 1ns/1ps
`default_nettype none
module dmpd_divider_tb_top;
    logic clk = 1'h0, resetn = 1'h0, ext_ref_detect = 1'h0, ref_clk = 1'h0;
    logic pfd_large_pulse = 1'h0, tuned_oscillator_clock, int_ref, ext_ref;
    logic loop33_clk, terminal_pulse, pd_terminal, modulus_select, div10_out;
    logic ref_sel, ref_div3, ref_1mhz, ref_100khz, loop33_div10, unlocked;
    logic [3:0] tens_req = 4'h1, units_req = 4'h0, preset_units, preset_tens;
    int errors = 0, comparisons = 0, cyc = 0, mark = 0;
    dmpd_divider dut_u (.*);
    dmpd_far_side far_u (.*);
    // clk/8 oscillator: slow enough for the edge synchroniser
    assign {loop33_clk, tuned_oscillator_clock, int_ref} = cyc[3:1];
    assign ext_ref = ~cyc[1];
    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(negedge clk) if (cyc == 20000) test_done(1'h1);
    task automatic check(input logic ok);
        comparisons++;
        errors += int'(ok !== 1'h1);
        if (ok !== 1'h1) $display("mismatch at %0t: wrong value", $time);
    endtask : check
    task automatic div_case(input logic [3:0] t, u, input logic v);
        @(posedge clk);
        {tens_req, units_req} <= {t, u};
        {ext_ref_detect, pfd_large_pulse} <= {v, v};
        repeat (2) do @(negedge clk); while (terminal_pulse !== 1'h1);
        mark = cyc;
        do @(negedge clk); while (terminal_pulse !== 1'h1);
        check(cyc - mark == 8 * (10 * (t + 2) + u));
        check(modulus_select === (u != 4'h0));
        check(ref_sel === v && unlocked === v);
    endtask : div_case
    task automatic rise_gap(input int sel, input int want);
        logic s, p;
        int t0, n;
        n = 0;
        t0 = 0;
        p = 1'h1;
        while (n < 2) begin
            @(negedge clk);
            case (sel)
                0: s = div10_out;
                1: s = ref_1mhz;
                2: s = ref_100khz;
                3: s = loop33_div10;
                default: s = ref_div3;
            endcase
            if (s === 1'h1 && p === 1'h0) begin
                if (n == 0) t0 = cyc;
                n++;
            end
            p = s;
        end
        check(cyc - t0 == want);
    endtask : rise_gap
    task automatic test_done(input logic hung);
        errors += int'(hung);
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'h1;
        div_case(4'h0, 4'h0, 1'h1);
        div_case(4'h9, 4'h9, 1'h0);
        rise_gap(0, 80);
        rise_gap(1, 40);
        rise_gap(2, 400);
        rise_gap(3, 160);
        rise_gap(4, 12);
        test_done(1'h0);
    end
endmodule : dmpd_divider_tb_top
`default_nettype wire

// *** dmpd_far_side.sv ***
// far side model: preset digit source for the divider
`timescale 1ns/1ps
`default_nettype none
module dmpd_far_side (
    input wire logic       clk,
    input wire logic       pd_terminal,
    input wire logic [3:0] tens_req,
    input wire logic [3:0] units_req,
    output logic     [3:0] preset_tens = 4'h1,
    output logic     [3:0] preset_units = 4'h0
);
    always @(posedge clk) if (pd_terminal)
        {preset_tens, preset_units} <= {tens_req, units_req};
endmodule : dmpd_far_side
`default_nettype wire

// *** dmpd_pkg.sv ***
// constants for the dual modulus divider and reference dividers
package dmpd_pkg;
    localparam int          DMPD_DIGIT_W   = 4;
    localparam logic [3:0]  DMPD_DEC_MAX   = 4'h9;
    localparam logic [3:0]  DMPD_PRE_LO    = 4'h9;  // divide by 10: 0..9
    localparam logic [3:0]  DMPD_PRE_HI    = 4'ha;  // divide by 11: 0..10
    localparam logic [3:0]  DMPD_ZERO      = 4'h0;
    localparam logic [1:0]  DMPD_DIV3_MAX  = 2'h2;
    localparam logic [3:0]  DMPD_DIV10_MAX = 4'h9;
    localparam logic [3:0]  DMPD_HALF10    = 4'h5;
    localparam int          DMPD_LOCK_W    = 4;
    localparam logic [3:0]  DMPD_LOCK_LIM  = 4'h3;
endpackage : dmpd_pkg
